// *** bench/switch_bank.sv ***
`timescale 1ns/10ps
module switch_bank (
  // clock
  input wire logic clk_sys,
  // wanted levels, bit 0 scl .. bit 4 pulse input
  input wire logic [4:0] want,
  // pins
  output logic pin_scl,
  output logic pin_sda,
  output logic pin_tx,
  output logic pin_rx,
  output logic pulse_input_pin
);
  always_ff @(posedge clk_sys) begin
    {pulse_input_pin, pin_rx, pin_tx, pin_sda, pin_scl} <= want;
  end
endmodule : switch_bank

// *** bench/switch_input_role_mapper_tb_top.sv ***
`timescale 1ns/10ps
module switch_input_role_mapper_tb_top;
  import switch_map_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pin_scl, pin_sda, pin_tx, pin_rx, pulse_input_pin;
  logic kill_switch, forward_limit, reverse_limit, irq;
  logic [4:0] want = 5'h00, m;
  logic [9:0] maps [4] = '{IDX_ACTIVE_LEVEL, IDX_EMERGENCY_STOP, IDX_FORWARD_END_STOP,
    IDX_REVERSE_END_STOP};
  logic [3:0] codes [5] = '{4'h0, 4'h2, FUNC_KILL, FUNC_FORWARD_LIMIT, FUNC_REVERSE_LIMIT};
  int failures = 0, n_tests = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  switch_bank switch_bank_inst (.clk_sys(clk_sys), .want(want), .pin_scl(pin_scl),
    .pin_sda(pin_sda), .pin_tx(pin_tx), .pin_rx(pin_rx), .pulse_input_pin(pulse_input_pin));
  switch_input_role_mapper switch_input_role_mapper_inst (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_scl(pin_scl), .pin_sda(pin_sda),
    .pin_tx(pin_tx), .pin_rx(pin_rx), .pulse_input_pin(pulse_input_pin),
    .kill_switch(kill_switch), .forward_limit(forward_limit), .reverse_limit(reverse_limit),
    .irq(irq));
  // ----
  // helpers
  // ----
  task end_sim();
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] i, input logic [1:0] lo, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(negedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic role(input logic [4:0] mp, l, p);
    return |(mp & ~(p ^ l));
  endfunction : role
  task cfg(input logic [4:0] l, k, f, r, p);
    apb(1'b1, IDX_ACTIVE_LEVEL, 2'h0, {27'h0, l});
    apb(1'b1, IDX_EMERGENCY_STOP, 2'h0, {27'h0, k});
    apb(1'b1, IDX_FORWARD_END_STOP, 2'h0, {27'h0, f});
    apb(1'b1, IDX_REVERSE_END_STOP, 2'h0, {27'h0, r});
    @(posedge clk_sys);
    want <= p;
    repeat (3) @(posedge clk_sys);
    chk(kill_switch, role(k, l, p));
    chk(forward_limit, role(f, l, p));
    chk(reverse_limit, role(r, l, p));
    apb(1'b0, IDX_ACTIVE_LEVEL, 2'h0, 32'h0);
    chk(rd, {27'h0, l});
    apb(1'b0, IDX_REVERSE_END_STOP, 2'h0, 32'h0);
    chk(rd, {27'h0, r});
  endtask : cfg
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h0d50a216));
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (maps[i]) begin
      apb(1'b0, maps[i], 2'h0, 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      m = 5'h01 << i;
      cfg(5'h00, m, 5'h00, 5'h00, ~m);
      cfg(5'h1f, 5'h00, m, m, m);
    end
    repeat (40) cfg(5'($urandom), 5'($urandom), 5'($urandom), 5'($urandom), 5'($urandom));
    apb(1'b0, 10'h3ff, 2'h0, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, IDX_EMERGENCY_STOP, 2'h1, 32'h1f);
    chk(err, 1'b1);
    cfg(5'h00, 5'h01, 5'h00, 5'h00, 5'h1e);
    foreach (codes[i]) begin
      apb(1'b1, IDX_FUNC_SCL, 2'h0, {28'h0, codes[i]});
      apb(1'b0, IDX_LIVE_STATE, 2'h0, 32'h0);
      chk(rd[0], i > 1);
    end
    cfg(5'h00, 5'h01, 5'h00, 5'h00, 5'h1f);
    apb(1'b1, IDX_IRQ_CLEAR, 2'h0, 32'h7);
    apb(1'b1, IDX_IRQ_ENABLE, 2'h0, 32'h1);
    want <= 5'h1e;
    repeat (3) @(posedge clk_sys);
    chk({irq, kill_switch}, 2'h3);
    want <= 5'h1f;
    apb(1'b1, IDX_IRQ_ENABLE, 2'h0, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    apb(1'b0, IDX_IRQ_STATUS, 2'h0, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, IDX_IRQ_CLEAR, 2'h0, 32'h1);
    apb(1'b0, IDX_IRQ_STATUS, 2'h0, 32'h0);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule : switch_input_role_mapper_tb_top

// *** bench/switch_map_checker_assertions.sv ***
`timescale 1ns/10ps
module switch_map_checker
  import switch_map_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and outputs
  input wire logic pin_scl,
  input wire logic pin_sda,
  input wire logic pin_tx,
  input wire logic pin_rx,
  input wire logic pulse_input_pin,
  input wire logic kill_switch,
  input wire logic forward_limit,
  input wire logic reverse_limit
);
  // ----
  // shadow of the map bytes
  // ----
  logic [4:0] lv, km, fm, rm;
  wire [9:0] ix = paddr[11:2];
  wire wr = psel & penable & pready & pwrite & !pslverr;
  wire [4:0] act = ~({pulse_input_pin, pin_rx, pin_tx, pin_sda, pin_scl} ^ lv);
  wire kx = |(km & act);
  wire fx = |(fm & act);
  wire rx = |(rm & act);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lv <= 5'h00;
      km <= 5'h00;
      fm <= 5'h00;
      rm <= 5'h00;
    end else if (wr) begin
      if (ix == IDX_ACTIVE_LEVEL) lv <= pwdata[4:0];
      if (ix == IDX_EMERGENCY_STOP) km <= pwdata[4:0];
      if (ix == IDX_FORWARD_END_STOP) fm <= pwdata[4:0];
      if (ix == IDX_REVERSE_END_STOP) rm <= pwdata[4:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_err_misaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned accepted");
  a_kill_follows_pins: assert property (kill_switch == $past(kx)) else $error("kill");
  a_fwd_follows_pins: assert property (forward_limit == $past(fx)) else $error("fwd");
  a_rev_follows_pins: assert property (reverse_limit == $past(rx)) else $error("rev");
  a_kill_map_readback: assert property (pready && !pwrite && ix == IDX_EMERGENCY_STOP |->
    prdata == {27'h0, km}) else $error("kill map");
  a_level_readback: assert property (pready && !pwrite && ix == IDX_ACTIVE_LEVEL |->
    prdata == {27'h0, lv}) else $error("level map");
endmodule : switch_map_checker
bind switch_input_role_mapper switch_map_checker switch_map_checker_inst (.clk_sys(clk_sys),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_scl(pin_scl),
  .pin_sda(pin_sda), .pin_tx(pin_tx), .pin_rx(pin_rx), .pulse_input_pin(pulse_input_pin),
  .kill_switch(kill_switch), .forward_limit(forward_limit), .reverse_limit(reverse_limit));

// *** src/switch_input_role_mapper.sv ***
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - polarity byte holds one active-level bit per pin, bits 0..4 in pin order
// - active-level bit 0: switch active while pin is low
// - active-level bit 1: switch active while pin is high
// - active level applies to every pin set in a membership byte; the function code gates only the live-state pin bits
// - kill membership byte holds one bit per pin, bits 0..4 in pin order
// - kill bit 0 means not a kill switch, 1 means kill switch
// - forward-limit byte: set bit marks that pin as forward limit switch
// - reverse-limit byte: set bit marks that pin as reverse limit switch
// - function in low four bits; 7 kill, 8 forward, 9 reverse
module switch_input_role_mapper
  import switch_map_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // switch pins
  input wire logic pin_scl,
  input wire logic pin_sda,
  input wire logic pin_tx,
  input wire logic pin_rx,
  input wire logic pulse_input_pin,
  // decoded switch outputs
  output logic kill_switch,
  output logic forward_limit,
  output logic reverse_limit,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] switch_active_level_setting;
    logic [NUM_PINS-1:0] emergency_stop_pin_set;
    logic [NUM_PINS-1:0] forward_end_stop_pin_set;
    logic [NUM_PINS-1:0] reverse_end_stop_pin_set;
    logic [NUM_PINS-1:0][FUNC_W-1:0] pin_func;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_enable;
    logic kill_switch;
    logic forward_limit;
    logic reverse_limit;
    logic irq;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic is_switch_func(input logic [FUNC_W-1:0] code);
    is_switch_func = (code == FUNC_KILL) || (code == FUNC_FORWARD_LIMIT) ||
      (code == FUNC_REVERSE_LIMIT);
  endfunction : is_switch_func

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    is_mapped = (addr[1:0] == 2'h0) && (idx == IDX_ACTIVE_LEVEL ||
      idx == IDX_EMERGENCY_STOP || idx == IDX_FORWARD_END_STOP ||
      idx == IDX_REVERSE_END_STOP || idx == IDX_FUNC_SCL || idx == IDX_FUNC_SDA ||
      idx == IDX_FUNC_TX || idx == IDX_FUNC_RX || idx == IDX_FUNC_PULSE ||
      idx == IDX_IRQ_STATUS || idx == IDX_IRQ_CLEAR || idx == IDX_IRQ_ENABLE ||
      idx == IDX_LIVE_STATE);
  endfunction : is_mapped

  // ------------------------------------------------------------
  // per-pin active level
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_active;
  logic [NUM_PINS-1:0] pin_switch_active;

  assign pin_level = {pulse_input_pin, pin_rx, pin_tx, pin_sda, pin_scl};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // active when the pin level equals its active-level bit
      assign pin_active[gi] = ~(pin_level[gi] ^ cur.switch_active_level_setting[gi]);
      assign pin_switch_active[gi] = pin_active[gi] & is_switch_func(cur.pin_func[gi]);
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [9:0] idx;
  logic setup;
  logic access;
  logic [NUM_EVENTS-1:0] roles;
  logic [NUM_EVENTS-1:0] rises;
  logic [NUM_EVENTS-1:0] clr;

  always_comb begin
    next_cur = cur;
    idx = paddr[ADDR_W-1:2];
    setup = psel && !penable;
    access = psel && penable && cur.pready;
    clr = '0;
    // role outputs from membership and active level
    roles[EV_KILL] = |(cur.emergency_stop_pin_set & pin_active);
    roles[EV_FORWARD] = |(cur.forward_end_stop_pin_set & pin_active);
    roles[EV_REVERSE] = |(cur.reverse_end_stop_pin_set & pin_active);
    rises = roles & ~{cur.reverse_limit, cur.forward_limit, cur.kill_switch};
    next_cur.kill_switch = roles[EV_KILL];
    next_cur.forward_limit = roles[EV_FORWARD];
    next_cur.reverse_limit = roles[EV_REVERSE];
    // apb answer: ready for one cycle after setup
    next_cur.pready = setup;
    next_cur.pslverr = setup && !is_mapped(paddr);
    if (setup) begin
      next_cur.prdata = '0;
      unique case (idx)
        IDX_ACTIVE_LEVEL: next_cur.prdata[NUM_PINS-1:0] = cur.switch_active_level_setting;
        IDX_EMERGENCY_STOP: next_cur.prdata[NUM_PINS-1:0] = cur.emergency_stop_pin_set;
        IDX_FORWARD_END_STOP: next_cur.prdata[NUM_PINS-1:0] = cur.forward_end_stop_pin_set;
        IDX_REVERSE_END_STOP: next_cur.prdata[NUM_PINS-1:0] = cur.reverse_end_stop_pin_set;
        IDX_FUNC_SCL: next_cur.prdata[FUNC_W-1:0] = cur.pin_func[PIN_SCL];
        IDX_FUNC_SDA: next_cur.prdata[FUNC_W-1:0] = cur.pin_func[PIN_SDA];
        IDX_FUNC_TX: next_cur.prdata[FUNC_W-1:0] = cur.pin_func[PIN_TX];
        IDX_FUNC_RX: next_cur.prdata[FUNC_W-1:0] = cur.pin_func[PIN_RX];
        IDX_FUNC_PULSE: next_cur.prdata[FUNC_W-1:0] = cur.pin_func[PIN_PULSE];
        IDX_IRQ_STATUS: next_cur.prdata[NUM_EVENTS-1:0] = cur.irq_status;
        IDX_IRQ_ENABLE: next_cur.prdata[NUM_EVENTS-1:0] = cur.irq_enable;
        IDX_LIVE_STATE: begin
          next_cur.prdata[LIVE_PINS_LSB +: NUM_PINS] = pin_switch_active;
          next_cur.prdata[LIVE_ROLES_LSB +: NUM_EVENTS] =
            {cur.reverse_limit, cur.forward_limit, cur.kill_switch};
        end
        default: next_cur.prdata = '0;
      endcase
      if (paddr[1:0] != 2'h0) begin
        next_cur.prdata = '0;
      end
    end
    // apb write at the access edge; bits 5..7 are not stored
    if (access && pwrite && !cur.pslverr) begin
      unique case (idx)
        IDX_ACTIVE_LEVEL: next_cur.switch_active_level_setting = pwdata[NUM_PINS-1:0];
        IDX_EMERGENCY_STOP: next_cur.emergency_stop_pin_set = pwdata[NUM_PINS-1:0];
        IDX_FORWARD_END_STOP: next_cur.forward_end_stop_pin_set = pwdata[NUM_PINS-1:0];
        IDX_REVERSE_END_STOP: next_cur.reverse_end_stop_pin_set = pwdata[NUM_PINS-1:0];
        IDX_FUNC_SCL: next_cur.pin_func[PIN_SCL] = pwdata[FUNC_W-1:0];
        IDX_FUNC_SDA: next_cur.pin_func[PIN_SDA] = pwdata[FUNC_W-1:0];
        IDX_FUNC_TX: next_cur.pin_func[PIN_TX] = pwdata[FUNC_W-1:0];
        IDX_FUNC_RX: next_cur.pin_func[PIN_RX] = pwdata[FUNC_W-1:0];
        IDX_FUNC_PULSE: next_cur.pin_func[PIN_PULSE] = pwdata[FUNC_W-1:0];
        IDX_IRQ_CLEAR: clr = pwdata[NUM_EVENTS-1:0];
        IDX_IRQ_ENABLE: next_cur.irq_enable = pwdata[NUM_EVENTS-1:0];
        default: clr = '0;
      endcase
    end
    // sticky events: a set in the same cycle wins over a clear
    next_cur.irq_status = (cur.irq_status & ~clr) | rises;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_enable);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur.switch_active_level_setting <= RESET_MAP;
      cur.emergency_stop_pin_set <= RESET_MAP;
      cur.forward_end_stop_pin_set <= RESET_MAP;
      cur.reverse_end_stop_pin_set <= RESET_MAP;
      cur.pin_func <= {NUM_PINS{RESET_FUNC}};
      cur.irq_status <= RESET_EVENTS;
      cur.irq_enable <= RESET_EVENTS;
      cur.kill_switch <= 1'b0;
      cur.forward_limit <= 1'b0;
      cur.reverse_limit <= 1'b0;
      cur.irq <= 1'b0;
      cur.prdata <= '0;
      cur.pready <= 1'b0;
      cur.pslverr <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign kill_switch = cur.kill_switch;
  assign forward_limit = cur.forward_limit;
  assign reverse_limit = cur.reverse_limit;
  assign irq = cur.irq;

endmodule : switch_input_role_mapper

// *** src/switch_map_pkg.sv ***
package switch_map_pkg;

  // ------------------------------------------------------------
  // pin order and widths
  // ------------------------------------------------------------
  localparam int NUM_PINS = 5;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_TX = 2;
  localparam int PIN_RX = 3;
  localparam int PIN_PULSE = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FUNC_W = 4;
  localparam int NUM_EVENTS = 3;

  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_ACTIVE_LEVEL = 10'h036;
  localparam logic [9:0] IDX_EMERGENCY_STOP = 10'h05d;
  localparam logic [9:0] IDX_FORWARD_END_STOP = 10'h05f;
  localparam logic [9:0] IDX_REVERSE_END_STOP = 10'h060;
  localparam logic [9:0] IDX_FUNC_SCL = 10'h070;
  localparam logic [9:0] IDX_FUNC_SDA = 10'h071;
  localparam logic [9:0] IDX_FUNC_TX = 10'h072;
  localparam logic [9:0] IDX_FUNC_RX = 10'h03e;
  localparam logic [9:0] IDX_FUNC_PULSE = 10'h03f;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h080;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h081;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h082;
  localparam logic [9:0] IDX_LIVE_STATE = 10'h083;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int LIVE_PINS_LSB = 0;
  localparam int LIVE_ROLES_LSB = 8;
  localparam int EV_KILL = 0;
  localparam int EV_FORWARD = 1;
  localparam int EV_REVERSE = 2;
  localparam logic [NUM_PINS-1:0] RESET_MAP = 5'h00;
  localparam logic [FUNC_W-1:0] RESET_FUNC = 4'h0;
  localparam logic [NUM_EVENTS-1:0] RESET_EVENTS = 3'h0;

  // ------------------------------------------------------------
  // pin function codes
  // ------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FUNC_KILL = 4'h7;
  localparam logic [FUNC_W-1:0] FUNC_FORWARD_LIMIT = 4'h8;
  localparam logic [FUNC_W-1:0] FUNC_REVERSE_LIMIT = 4'h9;

endpackage : switch_map_pkg
